// ==== hw/trd_pkg.sv ====
package trd_pkg;

    // backplane word layout
    localparam int TB_WIDTH = 96;
    localparam int SEL_LSB = 0;
    localparam int SEL_WIDTH = 8;
    localparam int CMD_LSB = 8;
    localparam int DAQ_LSB = 12;
    localparam int TOK_LSB = 16;
    localparam int NIB_WIDTH = 4;
    localparam int TOK_WIDTH = 12;
    localparam int TOK_DEPTH = 4096;

    // trigger command codes
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_FIRST_HOUSE = 4'hD;
    localparam logic [3:0] CMD_ABORT = 4'hD;
    localparam logic [3:0] CMD_L1_ACCEPT = 4'hE;
    localparam logic [3:0] CMD_L2_ACCEPT = 4'hF;

    // link timing in link clock cycles
    localparam int SLOTS = 5;
    localparam int DCLK_HALF = 3;
    localparam int LINK_PER_DCLK = 2 * DCLK_HALF;
    localparam int COLL_PER = SLOTS * LINK_PER_DCLK;
    localparam int COLL_HALF = COLL_PER / 2;
    localparam int PH_WIDTH = 5;
    localparam int HALF_WIDTH = 8;
    localparam logic [7:0] MIN_HALF = 8'(DCLK_HALF);
    localparam logic [7:0] VTX_FAST_HALF = 8'(COLL_PER / 6);
    localparam logic [7:0] VTX_SLOW_HALF = 8'(COLL_PER * 3 / 2);
    localparam logic [4:0] PH_LAST = 5'(COLL_PER - 1);
    localparam logic [4:0] PH_STROBE_HIGH = 5'(COLL_HALF);
    localparam logic [2:0] DPH_HIGH = 3'(DCLK_HALF);
    localparam logic [2:0] DPH_LAST = 3'(LINK_PER_DCLK - 1);

    // detector kinds, caught from a strap after reset
    localparam logic DET_DRIFT = 1'b0;
    localparam logic DET_VERTEX = 1'b1;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] daq;
        logic [11:0] token;
    } trd_frame_t;

    typedef enum logic [0:0] {
        TRD_IDLE = 1'b0,
        TRD_SEND = 1'b1
    } trd_link_state_t;

endpackage : trd_pkg

// ==== hw/trd_sync3.sv ====
`timescale 1ns/1ps
module trd_sync3 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire [W-1:0] agree = ~(s2 ^ s3);

    // a bit moves only once the second and third stages agree
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= (s3 & agree) | (q & ~agree);
        end
    end

endmodule : trd_sync3

// ==== hw/trd_clk_div.sv ====
`timescale 1ns/1ps
module trd_clk_div (
    input wire logic clock,
    input wire logic nrst,
    input wire logic restart,
    input wire logic [7:0] half,
    output logic clk_out
);

    logic [7:0] cnt;
    wire at_end = (cnt == 8'(half - 8'h01));

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 8'h00;
            clk_out <= 1'b0;
        end
        else if (restart)
        begin
            cnt <= 8'h00;
            clk_out <= 1'b1;
        end
        else if (at_end)
        begin
            cnt <= 8'h00;
            clk_out <= ~clk_out;
        end
        else
        begin
            cnt <= 8'(cnt + 8'h01);
        end
    end

endmodule : trd_clk_div

// ==== hw/trd_root.sv ====
// What this block does
// - every trigger sends a 4-bit DAQ command to each selected detector
// - DAQ command is passed along untouched, same value to all detectors
// - a whole trigger command goes out within five strobe periods
// - all 20 bits go out inside one crossing period, no dead time
// - a powered-down receiver on a shared branch must not disturb others
// - nothing on the link toggles faster than five times collider rate
// - separate front-end busy and DAQ busy accepted per detector
// - never abort an event once its data was fully sent to DAQ
// - two detector-specific clocks made here, sent with the strobe
// - vertex detector: clock one three times, clock two a third
// - drift detector: both clocks settable sample clocks near 10 MHz
// - any detector clock rate allowed while under the link maximum
// - repeater delay set by jumpers only, no software setting
// - root takes 96 trigger bits and collider strobe from backplane
// - a 12-bit token travels with every trigger, accept and abort
// - five nibbles on four lines with word clock at five times strobe
// - nibbles change on data clock rise, trigger command first at strobe
// - last non-zero trigger command stays presented
`timescale 1ns/1ps
module trd_root #(
    parameter int DET_SLOT = 0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic collider_strobe_clock,
    input wire logic [95:0] trigger_bits,
    input wire logic fe_busy,
    input wire logic daq_busy,
    input wire logic det_kind,
    input wire logic [2:0] delay_strap,
    input wire logic [7:0] drift_half_1,
    input wire logic [7:0] drift_half_2,
    output logic link_strobe,
    output logic link_data_clock,
    output logic [3:0] link_data,
    output logic det_clock_1,
    output logic det_clock_2,
    output logic backplane_busy_n,
    output logic backplane_busy_oe,
    output logic [3:0] last_trigger_cmd
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic starts_event(input logic [3:0] c);
        starts_event = (c != trd_pkg::CMD_NONE) &&
            (c < trd_pkg::CMD_FIRST_HOUSE);
    endfunction : starts_event

    function automatic logic [7:0] clamp_half(input logic [7:0] h);
        clamp_half = (h < trd_pkg::MIN_HALF) ? trd_pkg::MIN_HALF : h;
    endfunction : clamp_half

    ////////////////////////////////////////////////////////////////////////
    // system domain: backplane capture

    logic strobe_s;
    logic strobe_d;
    logic [1:0] busy_s;
    logic req_tog;
    logic ack_s;
    logic ack_tog;
    trd_pkg::trd_frame_t hold_frame;
    logic readout_done [0:4095];

    trd_sync3 #(.W(1)) u_strobe_sync (
        .clock(clock),
        .nrst(nrst),
        .d(collider_strobe_clock),
        .q(strobe_s)
    );

    trd_sync3 #(.W(2)) u_busy_sync (
        .clock(clock),
        .nrst(nrst),
        .d({fe_busy, daq_busy}),
        .q(busy_s)
    );

    trd_sync3 #(.W(1)) u_ack_sync (
        .clock(clock),
        .nrst(nrst),
        .d(ack_tog),
        .q(ack_s)
    );

    // backplane bits are held by the control unit for the whole period,
    // so sampling a few cycles after the strobe edge is safe
    wire strobe_rise = strobe_s & ~strobe_d;
    wire selected = trigger_bits[trd_pkg::SEL_LSB + DET_SLOT];
    trd_pkg::trd_frame_t in_frame;
    assign in_frame.cmd = trigger_bits[trd_pkg::CMD_LSB +: 4];
    assign in_frame.daq = trigger_bits[trd_pkg::DAQ_LSB +: 4];
    assign in_frame.token = trigger_bits[trd_pkg::TOK_LSB +: 12];
    wire in_abort = in_frame.cmd == trd_pkg::CMD_ABORT;
    wire in_l2 = in_frame.cmd == trd_pkg::CMD_L2_ACCEPT;
    wire done_bit = readout_done[in_frame.token];
    wire abort_blocked = in_abort & done_bit;
    wire hs_busy = req_tog != ack_s;
    wire take = strobe_rise & selected &
        (in_frame.cmd != trd_pkg::CMD_NONE) & ~abort_blocked & ~hs_busy;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            strobe_d <= 1'b0;
            req_tog <= 1'b0;
            hold_frame <= '0;
            last_trigger_cmd <= 4'h0;
        end
        else
        begin
            strobe_d <= strobe_s;
            if (take)
            begin
                hold_frame <= in_frame;
                req_tog <= ~req_tog;
                last_trigger_cmd <= in_frame.cmd;
            end
        end
    end

    // once the second accept went out the event may leave for DAQ,
    // so a later abort for that token is dropped
    always_ff @(posedge clock)
    begin
        if (strobe_rise && selected && in_l2)
        begin
            readout_done[in_frame.token] <= 1'b1;
        end
        else if (strobe_rise && selected && starts_event(in_frame.cmd))
        begin
            readout_done[in_frame.token] <= 1'b0;
        end
    end

    // one open-drain line per detector carries the OR of both busies
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            backplane_busy_n <= 1'b0;
            backplane_busy_oe <= 1'b0;
        end
        else
        begin
            backplane_busy_n <= 1'b0;
            backplane_busy_oe <= busy_s[1] | busy_s[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: reset release and straps

    logic lrst_a;
    logic lrst_n;
    logic straps_taken;
    logic kind;
    logic [4:0] phase;
    logic [7:0] half_1;
    logic [7:0] half_2;
    logic [1:0] frame_cnt;

    always_ff @(posedge link_clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lrst_a <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_a <= 1'b1;
            lrst_n <= lrst_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: frame handshake and nibble sender

    logic req_s;
    logic req_seen;
    logic pending;
    trd_pkg::trd_frame_t frame_l;
    trd_pkg::trd_link_state_t state;
    logic [19:0] shreg;

    trd_sync3 #(.W(1)) u_req_sync (
        .clock(link_clock),
        .nrst(lrst_n),
        .d(req_tog),
        .q(req_s)
    );

    wire new_req = req_s != req_seen;
    wire [4:0] next_phase = (phase == trd_pkg::PH_LAST) ? 5'h00 :
        5'(phase + 5'h01);
    wire [2:0] next_dph = 3'(next_phase % 5'(trd_pkg::LINK_PER_DCLK));
    wire frame_edge = next_phase == 5'h00;
    wire start = frame_edge & pending;
    wire slot_edge = (next_dph == 3'h0) & ~frame_edge;

    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            req_seen <= 1'b0;
            ack_tog <= 1'b0;
            pending <= 1'b0;
            frame_l <= '0;
        end
        else
        begin
            if (new_req)
            begin
                // frame held stable on the other side until this ack
                frame_l <= hold_frame;
                req_seen <= req_s;
                ack_tog <= req_s;
            end
            pending <= new_req | (pending & ~start);
        end
    end

    // jumpers set the strobe phase; read once after reset, never by software
    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            straps_taken <= 1'b0;
            kind <= trd_pkg::DET_DRIFT;
            half_1 <= trd_pkg::MIN_HALF;
            half_2 <= trd_pkg::MIN_HALF;
            phase <= 5'h00;
        end
        else if (!straps_taken)
        begin
            straps_taken <= 1'b1;
            kind <= det_kind;
            half_1 <= clamp_half(drift_half_1);
            half_2 <= clamp_half(drift_half_2);
            phase <= 5'(delay_strap);
        end
        else
        begin
            phase <= next_phase;
        end
    end

    // outputs are the registered image of next_phase, so strobe rise,
    // data clock rise and the first nibble change on the same edge
    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state <= trd_pkg::TRD_IDLE;
            shreg <= 20'h00000;
            link_data <= 4'h0;
            link_strobe <= 1'b0;
            link_data_clock <= 1'b0;
        end
        else
        begin
            // driven lines never wait on a receiver: dead drops are harmless
            link_strobe <= next_phase < trd_pkg::PH_STROBE_HIGH;
            link_data_clock <= next_dph < trd_pkg::DPH_HIGH;
            if (frame_edge)
            begin
                // all five nibbles fit one period: back to back frames ok
                state <= start ? trd_pkg::TRD_SEND : trd_pkg::TRD_IDLE;
                link_data <= start ? frame_l.cmd : 4'h0;
                shreg <= {frame_l[15:0], 4'h0};
            end
            else if (slot_edge && state == trd_pkg::TRD_SEND)
            begin
                link_data <= shreg[19:16];
                shreg <= {shreg[15:0], 4'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // detector clocks

    // vertex clocks lock to the strobe; drift clocks run free at set rate
    wire vertex = kind == trd_pkg::DET_VERTEX;
    wire div_restart = vertex & frame_edge;
    // slow vertex clock spans three periods: realign only every third one,
    // else the restart would pin it high
    wire div_restart_2 = div_restart & (frame_cnt == 2'h0);

    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            frame_cnt <= 2'h0;
        end
        else if (frame_edge)
        begin
            frame_cnt <= (frame_cnt == 2'h2) ? 2'h0 : 2'(frame_cnt + 2'h1);
        end
    end
    wire [7:0] use_half_1 = vertex ? trd_pkg::VTX_FAST_HALF : half_1;
    wire [7:0] use_half_2 = vertex ? trd_pkg::VTX_SLOW_HALF : half_2;

    trd_clk_div u_det_div_1 (
        .clock(link_clock),
        .nrst(lrst_n),
        .restart(div_restart),
        .half(use_half_1),
        .clk_out(det_clock_1)
    );

    trd_clk_div u_det_div_2 (
        .clock(link_clock),
        .nrst(lrst_n),
        .restart(div_restart_2),
        .half(use_half_2),
        .clk_out(det_clock_2)
    );

endmodule : trd_root

// ==== sim/trd_chk.sv ====
`timescale 1ns/1ps
module trd_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic fe_busy,
    input wire logic daq_busy,
    input wire logic det_kind,
    input wire logic link_strobe,
    input wire logic link_data_clock,
    input wire logic [3:0] link_data,
    input wire logic det_clock_1,
    input wire logic det_clock_2,
    input wire logic backplane_busy_oe,
    input wire logic [3:0] last_trigger_cmd
);
    logic lock_1;
    logic lock_2;
    // divider pulses before the first strobe-aligned restart are not judged
    always_ff @(posedge link_clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lock_1 <= 1'b0;
            lock_2 <= 1'b0;
        end
        else
        begin
            if ($rose(det_clock_1) && $rose(link_strobe))
                lock_1 <= 1'b1;
            if ($rose(det_clock_2) && $rose(link_strobe))
                lock_2 <= 1'b1;
        end
    end
    sequence s_word;
        ##6 $rose(link_data_clock);
    endsequence
    property p_dclk;
        @(posedge link_clock) disable iff (!nrst)
        $rose(link_data_clock) |-> link_data_clock[*3] ##1
            !link_data_clock[*3] ##1 link_data_clock;
    endproperty
    a_dclk: assert property (p_dclk) else $error("data clock shape");
    property p_strobe;
        @(posedge link_clock) disable iff (!nrst)
        $rose(link_strobe) |-> $rose(link_data_clock) ##15 $fell(link_strobe);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe shape");
    property p_words;
        @(posedge link_clock) disable iff (!nrst)
        $rose(link_strobe) |-> s_word ##0 s_word ##0 s_word ##0 s_word
            ##0 s_word ##0 $rose(link_strobe);
    endproperty
    a_words: assert property (p_words) else $error("five words");
    property p_stable;
        @(posedge link_clock) disable iff (!nrst)
        !$rose(link_data_clock) |-> $stable(link_data);
    endproperty
    a_stable: assert property (p_stable) else $error("nibble moved");
    property p_vfast;
        @(posedge link_clock) disable iff (!nrst)
        lock_1 && det_kind && $rose(det_clock_1) |-> det_clock_1[*5] ##1
            !det_clock_1[*5] ##1 det_clock_1;
    endproperty
    a_vfast: assert property (p_vfast) else $error("fast clock");
    property p_vslow;
        @(posedge link_clock) disable iff (!nrst)
        lock_2 && det_kind && $rose(det_clock_2) |-> ##45 $fell(det_clock_2)
            ##45 $rose(det_clock_2);
    endproperty
    a_vslow: assert property (p_vslow) else $error("slow clock");
    property p_busy_on;
        @(posedge clock) disable iff (!nrst)
        (fe_busy || daq_busy)[*6] |-> backplane_busy_oe;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy lost");
    property p_busy_off;
        @(posedge clock) disable iff (!nrst)
        !(fe_busy || daq_busy)[*6] |-> !backplane_busy_oe;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("busy stuck");
    property p_last;
        @(posedge clock) disable iff (!nrst)
        $changed(last_trigger_cmd) |-> last_trigger_cmd != 4'h0;
    endproperty
    a_last: assert property (p_last) else $error("last cmd zero");
endmodule : trd_chk

bind trd_root trd_chk trd_chk_i (.clock, .nrst, .link_clock, .fe_busy,
    .daq_busy, .det_kind, .link_strobe, .link_data_clock, .link_data,
    .det_clock_1, .det_clock_2, .backplane_busy_oe, .last_trigger_cmd);

// ==== sim/trd_rx_model.sv ====
`timescale 1ns/1ps
module trd_rx_model (
    input wire logic link_strobe,
    input wire logic link_data_clock,
    input wire logic [3:0] link_data,
    output trd_pkg::trd_frame_t frame,
    output logic [3:0] last_cmd,
    output int n_frames
);
    // no busy returned through the tree; optional on this side
    // receiver only listens, so a dead drop cannot load the branch
    logic [19:0] sh = '0;
    int n_str = 0;
    int seen = 0;
    int slot = 0;
    initial
    begin
        frame = '0;
        last_cmd = 4'h0;
        n_frames = 0;
    end
    always @(posedge link_strobe)
        n_str++;
    // mid-eye latch; strobe edge restarts the slot count
    always @(negedge link_data_clock)
    begin
        if (n_str != seen)
        begin
            seen = n_str;
            slot = 0;
        end
        sh = {sh[15:0], link_data};
        slot++;
        if (slot == trd_pkg::SLOTS && sh[19:16] != trd_pkg::CMD_NONE)
        begin
            frame = sh;
            last_cmd = sh[19:16];
            n_frames++;
        end
    end
endmodule : trd_rx_model

// ==== sim/trigger_clock_distribution_test.sv ====
`timescale 1ns/1ps
module trigger_clock_distribution_test;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic link_clock = 1'b0;
    logic collider_strobe_clock = 1'b0;
    logic [95:0] trigger_bits = '0;
    logic fe_busy = 1'b0;
    logic daq_busy = 1'b0;
    logic det_kind = 1'b0;
    logic [2:0] delay_strap = 3'h0;
    logic [7:0] drift_half_1 = 8'h07;
    logic [7:0] drift_half_2 = 8'h01;
    logic pick = 1'b0;
    logic link_strobe, link_data_clock, det_clock_1, det_clock_2;
    logic backplane_busy_n, backplane_busy_oe;
    logic [3:0] link_data, last_trigger_cmd, rx_last;
    trd_pkg::trd_frame_t rx_frame;
    int n_frames;
    int bad_count = 0;
    int n_checks = 0;
    wire logic dcm = pick ? det_clock_2 : det_clock_1;

    initial
    begin
        forever #4 clock = ~clock;
    end
    initial
    begin
        #3;
        forever #24 link_clock = ~link_clock;
    end

    trd_root trd_root_i (.clock, .nrst, .link_clock, .collider_strobe_clock,
        .trigger_bits, .fe_busy, .daq_busy, .det_kind, .delay_strap,
        .drift_half_1, .drift_half_2, .link_strobe, .link_data_clock,
        .link_data, .det_clock_1, .det_clock_2, .backplane_busy_n,
        .backplane_busy_oe, .last_trigger_cmd);
    trd_rx_model trd_rx_model_i (.link_strobe, .link_data_clock,
        .link_data, .frame(rx_frame), .last_cmd(rx_last), .n_frames);

    ////////////////////////////////////////
    task chk_val(input string w, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : chk_val
    task chk_cnt(input string w, input int e, input int g);
        n_checks++;
        if (g != e)
        begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", w, e, g);
        end
    endtask : chk_cnt
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task do_reset(input logic kind, input logic [7:0] h1, h2);
        @(negedge clock);
        nrst = 1'b0;
        det_kind = kind;
        drift_half_1 = h1;
        drift_half_2 = h2;
        // long enough for two link edges
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (40) @(negedge clock);
    endtask : do_reset
    task trig(input logic sel, input logic [3:0] cmd, daq,
        input logic [11:0] tok, input logic want);
        int n0;
        int t;
        logic [3:0] prev;
        n0 = n_frames;
        prev = last_trigger_cmd;
        @(negedge clock);
        trigger_bits = '0;
        trigger_bits[trd_pkg::SEL_LSB] = sel;
        trigger_bits[trd_pkg::CMD_LSB +: 4] = cmd;
        trigger_bits[trd_pkg::DAQ_LSB +: 4] = daq;
        trigger_bits[trd_pkg::TOK_LSB +: 12] = tok;
        @(negedge clock);
        collider_strobe_clock = 1'b1;
        t = 0;
        // bound is five strobe periods of this bench
        while (n_frames == n0 && t < 900)
        begin
            @(negedge clock);
            t++;
            if (t == 90)
                collider_strobe_clock = 1'b0;
        end
        collider_strobe_clock = 1'b0;
        repeat (20) @(negedge clock);
        if (want)
        begin
            chk_cnt("frame seen", n0 + 1, n_frames);
            if (n_frames == n0)
                end_of_test();
            chk_val("cmd", cmd, rx_frame.cmd);
            chk_val("daq", daq, rx_frame.daq);
            chk_val("token", tok, rx_frame.token);
            chk_val("last cmd", cmd, last_trigger_cmd);
            chk_val("rx last", cmd, rx_last);
        end
        else
        begin
            chk_cnt("frames", n0, n_frames);
            chk_val("last cmd", prev, last_trigger_cmd);
        end
    endtask : trig
    task hi_len(output int n);
        int t;
        t = 0;
        n = 0;
        while (dcm !== 1'b0 && t < 200)
        begin
            @(negedge link_clock);
            t++;
        end
        while (dcm !== 1'b1 && t < 200)
        begin
            @(negedge link_clock);
            t++;
        end
        while (dcm === 1'b1 && t < 200)
        begin
            @(negedge link_clock);
            t++;
            n++;
        end
        if (t >= 200)
        begin
            chk_cnt("clock edges", 0, t);
            end_of_test();
        end
    endtask : hi_len

    ////////////////////////////////////////
    task t_codes;
        for (int i = 0; i < 16; i++)
            trig(1'b1, 4'(1 + i % 12), 4'(i), 12'(i * 12'h111), 1'b1);
        $display("test codes done");
    endtask : t_codes
    task t_refuse;
        trig(1'b0, 4'h3, 4'h5, 12'hABC, 1'b0);
        trig(1'b1, trd_pkg::CMD_NONE, 4'h5, 12'hABC, 1'b0);
        $display("test refuse done");
    endtask : t_refuse
    task t_abort;
        trig(1'b1, 4'h2, 4'h1, 12'h0F0, 1'b1);
        trig(1'b1, trd_pkg::CMD_L1_ACCEPT, 4'h1, 12'h0F0, 1'b1);
        trig(1'b1, trd_pkg::CMD_ABORT, 4'h1, 12'h0F0, 1'b1);
        trig(1'b1, 4'h4, 4'h0, 12'hFFF, 1'b1);
        trig(1'b1, trd_pkg::CMD_L2_ACCEPT, 4'h0, 12'hFFF, 1'b1);
        trig(1'b1, trd_pkg::CMD_ABORT, 4'h0, 12'hFFF, 1'b0);
        $display("test abort done");
    endtask : t_abort
    task t_busy;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock);
            fe_busy = i[0];
            daq_busy = i[1];
            repeat (10) @(negedge clock);
            chk_val("busy oe", 12'(i != 0), 12'(backplane_busy_oe));
            chk_val("busy level", 12'h000, 12'(backplane_busy_n));
        end
        $display("test busy done");
    endtask : t_busy
    task t_clocks;
        int n;
        do_reset(trd_pkg::DET_VERTEX, 8'h07, 8'h01);
        pick = 1'b0;
        hi_len(n);
        chk_cnt("vertex clock 1", trd_pkg::COLL_PER / 6, n);
        pick = 1'b1;
        hi_len(n);
        chk_cnt("vertex clock 2", trd_pkg::COLL_PER * 3 / 2, n);
        do_reset(trd_pkg::DET_DRIFT, 8'h07, 8'h01);
        pick = 1'b0;
        hi_len(n);
        chk_cnt("drift clock 1", 7, n);
        pick = 1'b1;
        hi_len(n);
        chk_cnt("drift clock 2", trd_pkg::DCLK_HALF, n);
        $display("test clocks done");
    endtask : t_clocks

    initial
    begin
        do_reset(trd_pkg::DET_DRIFT, 8'h07, 8'h01);
        t_codes();
        t_refuse();
        t_abort();
        t_busy();
        t_clocks();
        end_of_test();
    end
endmodule : trigger_clock_distribution_test
